// File: frs_pkg.sv
// Package of register indices, reset values, source codes and timing for the frequency reference selector.
package frs_pkg;
  // Bus geometry: each register index is one 32-bit word, byte address is four times the index.
  localparam int AXI_AW = 12;
  localparam int IDX_W = 10;
  localparam int REF_W = 16;
  localparam int ADC_W = 12;
  // Register indices.
  localparam logic [IDX_W-1:0] IDX_SERIAL_REFERENCE = 10'h002;
  localparam logic [IDX_W-1:0] IDX_REMOTE_SOURCE = 10'h104;
  localparam logic [IDX_W-1:0] IDX_UPPER_LIMIT = 10'h121;
  localparam logic [IDX_W-1:0] IDX_LOWER_LIMIT = 10'h122;
  localparam logic [IDX_W-1:0] IDX_LOCAL_SOURCE = 10'h180;
  localparam logic [IDX_W-1:0] IDX_MAX_FREQ = 10'h181;
  localparam logic [IDX_W-1:0] IDX_MIN_FREQ = 10'h182;
  localparam logic [IDX_W-1:0] IDX_PULSE_SCALE = 10'h183;
  localparam logic [IDX_W-1:0] IDX_STATUS_FREQ = 10'h190;
  localparam logic [IDX_W-1:0] IDX_STATUS_MODE = 10'h191;
  localparam logic [IDX_W-1:0] IDX_PRESET_BASE = 10'h200;
  localparam int PRESET_COUNT = 16;
  // Reset values.
  localparam logic [REF_W-1:0] RST_REMOTE_SOURCE = 16'h0000;
  localparam logic [REF_W-1:0] RST_LOCAL_SOURCE = 16'h0000;
  localparam logic [REF_W-1:0] RST_UPPER_LIMIT = 16'h0064;
  localparam logic [REF_W-1:0] RST_LOWER_LIMIT = 16'h0000;
  localparam logic [REF_W-1:0] RST_MAX_FREQ = 16'h1770;
  localparam logic [REF_W-1:0] RST_MIN_FREQ = 16'h0096;
  localparam logic [REF_W-1:0] RST_PULSE_SCALE = 16'h0BB8;
  localparam logic [REF_W-1:0] RST_PRESET = 16'h0000;
  localparam logic [REF_W-1:0] RST_SERIAL = 16'h0000;
  // Setting ranges.
  localparam logic [REF_W-1:0] REMOTE_SOURCE_MAX = 16'h0009;
  localparam logic [REF_W-1:0] LOCAL_SOURCE_MAX = 16'h0001;
  localparam logic [REF_W-1:0] UPPER_LIMIT_MAX = 16'h006E;
  localparam logic [REF_W-1:0] LOWER_LIMIT_MAX = 16'h006E;
  // Remote source codes.
  localparam logic [3:0] SRC_KNOB = 4'h0;
  localparam logic [3:0] SRC_PRESET = 4'h1;
  localparam logic [3:0] SRC_VOLTAGE = 4'h2;
  localparam logic [3:0] SRC_CURRENT_4_20 = 4'h3;
  localparam logic [3:0] SRC_CURRENT_0_20 = 4'h4;
  localparam logic [3:0] SRC_PULSE = 4'h5;
  localparam logic [3:0] SRC_SERIAL = 4'h6;
  localparam logic [3:0] SRC_MFA_VOLTAGE = 4'h7;
  localparam logic [3:0] SRC_MFA_CURRENT = 4'h8;
  localparam logic [3:0] SRC_OPTION = 4'h9;
  // Converter code of 4 mA on a 20 mA full scale.
  localparam logic [ADC_W-1:0] CODE_4MA = 12'h333;
  // Reciprocal of one hundred as 5243 / 2^19.
  localparam logic [12:0] PCT_RECIP = 13'h147B;
  localparam int PCT_SHIFT = 19;
  // Pulse train counting gate.
  localparam int CLK_MHZ = 100;
  localparam int PULSE_GATE_US = 1000;
  localparam int PULSE_GATE_CYCLES = CLK_MHZ * PULSE_GATE_US;
  localparam logic [9:0] GATES_PER_SECOND = 10'h3E8;
  localparam logic [5:0] DIV_STEPS = 6'h30;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : frs_pkg

// File: frs_pulse_src.sv
// Pulse train generator standing in for the far-side pulse source.
`timescale 1ns/10ps
`default_nettype none
module frs_pulse_src #(
  parameter int HALF = 10
) (
  input wire logic aclk,
  input wire logic run,
  output logic pulse
);
  int count;
  ////////////////////////////////////////////////////////////////
  // The line rests low between bursts, so no stray edge is counted.
  always_ff @(posedge aclk) begin
    if (!run) begin
      count <= 0;
      pulse <= 1'b0;
    end else if (count == HALF - 1) begin
      count <= 0;
      pulse <= !pulse;
    end else begin
      count <= count + 1;
    end
  end
endmodule : frs_pulse_src
`default_nettype wire

// File: frs_selector.sv
// Frequency reference selector with limit clamps and an AXI4-Lite register slave.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Remote mode source comes from a selector register, values 0 to 9, default 0.
// - Selector 0 uses the panel speed knob, top position giving maximum frequency.
// - Selector 1 uses preset reference one.
// - Selector 2 uses the 0 to 10 V terminal, 10 V giving maximum frequency.
// - Selectors 3 and 4 use 4-20 or 0-20 mA, only with current switch set.
// - Selector 5 uses the pulse train, scaled so the scale frequency gives maximum.
// - Selector 6 uses the reference written over the serial link.
// - Selector 7 uses multi-function voltage input, selector 8 multi-function current input.
// - Selector 9 uses the option card reference.
// - In multistep operation the selected source is step one, presets give steps 2-16.
// - Local mode source is knob at 0, keypad entry at 1, default 0.
// - Keypad entries are stored into preset reference one.
// - Limits apply in every mode and for every source.
// - Upper limit is 0 to 110 percent of maximum frequency, default 100.
// - Reference is held at or above the lower limit percentage.
// - Lower limit below minimum and reference below minimum gives no output.
// - The device starts in remote mode after reset.
module frs_selector #(
  parameter int GATE_CYCLES = frs_pkg::PULSE_GATE_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [frs_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [frs_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [frs_pkg::ADC_W-1:0] panel_speed_knob,
  input wire logic [frs_pkg::ADC_W-1:0] ref_voltage_in,
  input wire logic [frs_pkg::ADC_W-1:0] ref_current_in,
  input wire logic [frs_pkg::ADC_W-1:0] mfa_voltage_in,
  input wire logic [frs_pkg::ADC_W-1:0] mfa_current_in,
  input wire logic input_type_switch,
  input wire logic pulse_train_in,
  input wire logic local_mode_in,
  input wire logic [3:0] step_select,
  input wire logic [frs_pkg::REF_W-1:0] option_reference,
  input wire logic keypad_write,
  input wire logic [frs_pkg::REF_W-1:0] keypad_value,
  output logic [frs_pkg::REF_W-1:0] freq_reference,
  output logic output_active
);
  import frs_pkg::*;

  localparam int PIN_W = 5 * ADC_W + 7;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_sync_reg;
  logic pulse_last_reg;
  logic [ADC_W-1:0] knob_s, volt_s, cur_s, mfav_s, mfac_s;
  logic switch_s, pulse_s, local_s;
  logic [3:0] step_s;

  // Multi-bit converter words may tear for one cycle; they settle on the next.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pulse_last_reg <= 1'b0;
    end else begin
      pin_meta_reg <= {panel_speed_knob, ref_voltage_in, ref_current_in, mfa_voltage_in,
                       mfa_current_in, input_type_switch, pulse_train_in, local_mode_in, step_select};
      pin_sync_reg <= pin_meta_reg;
      pulse_last_reg <= pin_sync_reg[5];
    end
  end

  assign {knob_s, volt_s, cur_s, mfav_s, mfac_s, switch_s, pulse_s, local_s, step_s} = pin_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register file and AXI4-Lite slave.
  logic [REF_W-1:0] remote_source_reg, local_source_reg, upper_limit_reg, lower_limit_reg;
  logic [REF_W-1:0] max_freq_reg, min_freq_reg, pulse_scale_reg, serial_ref_reg;
  logic [REF_W-1:0] preset_reg [PRESET_COUNT];
  logic aw_full_reg, w_full_reg;
  logic [IDX_W-1:0] aw_idx_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire, wr_ok, rd_ok;
  logic [REF_W-1:0] rd_value;
  logic [IDX_W-1:0] rd_idx;
  logic [REF_W-1:0] wr_value;
  logic local_mode_reg;
  logic [REF_W-1:0] freq_reg;
  logic active_reg;

  function automatic logic [REF_W-1:0] merge(input logic [REF_W-1:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    logic [REF_W-1:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction : merge

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign rd_idx = s_axi_araddr[AXI_AW-1:2];

  always_comb begin
    wr_ok = 1'b1;
    unique case (aw_idx_reg)
      IDX_SERIAL_REFERENCE: wr_value = serial_ref_reg;
      IDX_REMOTE_SOURCE: wr_value = remote_source_reg;
      IDX_UPPER_LIMIT: wr_value = upper_limit_reg;
      IDX_LOWER_LIMIT: wr_value = lower_limit_reg;
      IDX_LOCAL_SOURCE: wr_value = local_source_reg;
      IDX_MAX_FREQ: wr_value = max_freq_reg;
      IDX_MIN_FREQ: wr_value = min_freq_reg;
      IDX_PULSE_SCALE: wr_value = pulse_scale_reg;
      default: begin
        wr_value = preset_reg[aw_idx_reg[3:0]];
        wr_ok = (aw_idx_reg[IDX_W-1:4] == IDX_PRESET_BASE[IDX_W-1:4]);
      end
    endcase
    wr_value = merge(wr_value, wdata_reg, wstrb_reg);
  end

  always_comb begin
    rd_ok = 1'b1;
    unique case (rd_idx)
      IDX_SERIAL_REFERENCE: rd_value = serial_ref_reg;
      IDX_REMOTE_SOURCE: rd_value = remote_source_reg;
      IDX_UPPER_LIMIT: rd_value = upper_limit_reg;
      IDX_LOWER_LIMIT: rd_value = lower_limit_reg;
      IDX_LOCAL_SOURCE: rd_value = local_source_reg;
      IDX_MAX_FREQ: rd_value = max_freq_reg;
      IDX_MIN_FREQ: rd_value = min_freq_reg;
      IDX_PULSE_SCALE: rd_value = pulse_scale_reg;
      IDX_STATUS_FREQ: rd_value = freq_reg;
      IDX_STATUS_MODE: rd_value = {10'h000, active_reg, local_mode_reg, step_s};
      default: begin
        rd_value = preset_reg[rd_idx[3:0]];
        rd_ok = (rd_idx[IDX_W-1:4] == IDX_PRESET_BASE[IDX_W-1:4]);
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_idx_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_idx_reg <= s_axi_awaddr[AXI_AW-1:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_ok ? rd_value : 16'h0000};
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Settings outside their range are ignored so the selectors never hold an illegal code.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_source_reg <= RST_REMOTE_SOURCE;
      local_source_reg <= RST_LOCAL_SOURCE;
      upper_limit_reg <= RST_UPPER_LIMIT;
      lower_limit_reg <= RST_LOWER_LIMIT;
      max_freq_reg <= RST_MAX_FREQ;
      min_freq_reg <= RST_MIN_FREQ;
      pulse_scale_reg <= RST_PULSE_SCALE;
      serial_ref_reg <= RST_SERIAL;
      for (int i = 0; i < PRESET_COUNT; i++) begin
        preset_reg[i] <= RST_PRESET;
      end
    end else begin
      if (wr_fire && wr_ok) begin
        unique case (aw_idx_reg)
          IDX_SERIAL_REFERENCE: serial_ref_reg <= wr_value;
          IDX_REMOTE_SOURCE: if (wr_value <= REMOTE_SOURCE_MAX) remote_source_reg <= wr_value;
          IDX_UPPER_LIMIT: if (wr_value <= UPPER_LIMIT_MAX) upper_limit_reg <= wr_value;
          IDX_LOWER_LIMIT: if (wr_value <= LOWER_LIMIT_MAX) lower_limit_reg <= wr_value;
          IDX_LOCAL_SOURCE: if (wr_value <= LOCAL_SOURCE_MAX) local_source_reg <= wr_value;
          IDX_MAX_FREQ: max_freq_reg <= wr_value;
          IDX_MIN_FREQ: min_freq_reg <= wr_value;
          IDX_PULSE_SCALE: pulse_scale_reg <= wr_value;
          default: preset_reg[aw_idx_reg[3:0]] <= wr_value;
        endcase
      end
      // The keypad wins over a bus write in the same cycle.
      if (keypad_write) begin
        preset_reg[0] <= keypad_value;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse train measurement: edges per gate, then a serial divide.
  logic [$clog2(GATE_CYCLES)-1:0] gate_cnt_reg;
  logic [REF_W-1:0] edge_cnt_reg;
  logic [47:0] div_num_reg;
  logic [16:0] div_rem_reg;
  logic [5:0] div_step_reg;
  logic div_busy_reg;
  logic [REF_W-1:0] pulse_ref_reg;
  logic [16:0] rem_shift;
  logic gate_tick;

  assign gate_tick = (gate_cnt_reg == ($clog2(GATE_CYCLES))'(GATE_CYCLES - 1));
  assign rem_shift = {div_rem_reg[15:0], div_num_reg[47]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_cnt_reg <= '0;
      edge_cnt_reg <= '0;
    end else begin
      gate_cnt_reg <= gate_tick ? '0 : gate_cnt_reg + 1'b1;
      if (gate_tick) begin
        edge_cnt_reg <= '0;
      end else if (pin_sync_reg[5] && !pulse_last_reg && edge_cnt_reg != 16'hFFFF) begin
        edge_cnt_reg <= edge_cnt_reg + 1'b1;
      end
    end
  end

  // Quotient is max frequency times pulse rate over the scale frequency.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_num_reg <= '0;
      div_rem_reg <= '0;
      div_step_reg <= '0;
      div_busy_reg <= 1'b0;
      pulse_ref_reg <= '0;
    end else if (gate_tick) begin
      div_num_reg <= 48'(max_freq_reg * edge_cnt_reg * GATES_PER_SECOND);
      div_rem_reg <= '0;
      div_step_reg <= '0;
      div_busy_reg <= (pulse_scale_reg != 16'h0000);
      if (pulse_scale_reg == 16'h0000) pulse_ref_reg <= '0;
    end else if (div_busy_reg) begin
      if (rem_shift >= {1'b0, pulse_scale_reg}) begin
        div_rem_reg <= rem_shift - {1'b0, pulse_scale_reg};
        div_num_reg <= {div_num_reg[46:0], 1'b1};
      end else begin
        div_rem_reg <= rem_shift;
        div_num_reg <= {div_num_reg[46:0], 1'b0};
      end
      div_step_reg <= div_step_reg + 1'b1;
      if (div_step_reg == DIV_STEPS - 1'b1) begin
        div_busy_reg <= 1'b0;
      end
    end else if (div_step_reg == DIV_STEPS) begin
      pulse_ref_reg <= (div_num_reg[47:16] != 32'h0) ? 16'hFFFF : div_num_reg[15:0];
      div_step_reg <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection and limits.
  function automatic logic [REF_W-1:0] scale_adc(input logic [REF_W-1:0] max_output_frequency, input logic [ADC_W-1:0] x);
    logic [28:0] p;
    p = max_output_frequency * {1'b0, x} + {13'h0000, max_output_frequency};
    return p[27:12];
  endfunction : scale_adc

  function automatic logic [ADC_W-1:0] live_zero(input logic [ADC_W-1:0] x);
    logic [14:0] t;
    t = 15'(x - CODE_4MA) * 15'h0005;
    if (x < CODE_4MA) return '0;
    return (t[14:2] > 13'h0FFF) ? 12'hFFF : t[13:2];
  endfunction : live_zero

  logic [REF_W-1:0] source_ref, step_ref, upper_freq, lower_freq, upper_done, clamped;
  logic [44:0] up_prod, low_prod;

  always_comb begin
    unique case (remote_source_reg[3:0])
      SRC_KNOB: source_ref = scale_adc(max_freq_reg, knob_s);
      SRC_PRESET: source_ref = preset_reg[0];
      SRC_VOLTAGE: source_ref = scale_adc(max_freq_reg, volt_s);
      SRC_CURRENT_4_20: source_ref = switch_s ? scale_adc(max_freq_reg, live_zero(cur_s)) : '0;
      SRC_CURRENT_0_20: source_ref = switch_s ? scale_adc(max_freq_reg, cur_s) : '0;
      SRC_PULSE: source_ref = pulse_ref_reg;
      SRC_SERIAL: source_ref = serial_ref_reg;
      SRC_MFA_VOLTAGE: source_ref = scale_adc(max_freq_reg, mfav_s);
      SRC_MFA_CURRENT: source_ref = scale_adc(max_freq_reg, live_zero(mfac_s));
      SRC_OPTION: source_ref = option_reference;
      default: source_ref = '0;
    endcase
    if (local_mode_reg) begin
      source_ref = local_source_reg[0] ? preset_reg[0] : scale_adc(max_freq_reg, knob_s);
    end
    step_ref = (step_s == 4'h0) ? source_ref : preset_reg[step_s];
    up_prod = 45'(max_freq_reg * upper_limit_reg[6:0] * PCT_RECIP);
    low_prod = 45'(max_freq_reg * lower_limit_reg[6:0] * PCT_RECIP);
    upper_freq = (up_prod[44:PCT_SHIFT] > 26'h000FFFF) ? 16'hFFFF : up_prod[PCT_SHIFT+15:PCT_SHIFT];
    lower_freq = (low_prod[44:PCT_SHIFT] > 26'h000FFFF) ? 16'hFFFF : low_prod[PCT_SHIFT+15:PCT_SHIFT];
    upper_done = (step_ref > upper_freq) ? upper_freq : step_ref;
    clamped = (upper_done < lower_freq) ? lower_freq : upper_done;
  end

  // Mode follows the synchronised mode pin, starting in remote from reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      local_mode_reg <= 1'b0;
    end else begin
      local_mode_reg <= local_s;
    end
  end

  // Clamp applies to every source and mode, so it sits after all selection.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freq_reg <= '0;
      active_reg <= 1'b0;
    end else if (lower_freq < min_freq_reg && step_ref < min_freq_reg) begin
      freq_reg <= '0;
      active_reg <= 1'b0;
    end else begin
      freq_reg <= clamped;
      active_reg <= 1'b1;
    end
  end

  assign freq_reference = freq_reg;
  assign output_active = active_reg;

endmodule : frs_selector
`default_nettype wire

// File: frs_selector_chk.sv
// Checker of the register bus handshakes and output qualifiers of the selector.
`timescale 1ns/10ps
`default_nettype none
module frs_selector_chk
  import frs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [frs_pkg::REF_W-1:0] freq_reference,
  input wire logic output_active
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
    freq_reference == 16'h0000 && !output_active && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not cleared by reset");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped before taken");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted during response");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid |=> ##1 s_axi_bvalid)
    else $error("write answer late");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  a_active_floor: assert property (output_active |-> freq_reference != 16'h0000)
    else $error("output active with zero reference");
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_stop: cover property ($fell(output_active));
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : frs_selector_chk
bind frs_selector frs_selector_chk frs_selector_chk_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .freq_reference(freq_reference), .output_active(output_active));
`default_nettype wire

// File: frs_selector_tb.sv
// Self-checking testbench of the frequency reference selector.
`timescale 1ns/10ps
`default_nettype none
module frs_selector_tb;
  import frs_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [AXI_AW-1:0] awaddr = '0;
  logic [AXI_AW-1:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic bready = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = '0;
  logic awready, wready, bvalid, arready, rvalid, pulse, act;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [ADC_W-1:0] knob = '0, vin = '0, iin = '0, mvin = '0, miin = '0;
  logic sw = 1'b0, pulse_run = 1'b0, local_mode = 1'b0, kw = 1'b0;
  logic [3:0] step = '0;
  logic [REF_W-1:0] opt = '0, kv = '0, reference_indicator;
  int n_errors = 0;
  int n_compared = 0;
  always #5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////
  frs_selector #(.GATE_CYCLES(100)) frs_selector_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .panel_speed_knob(knob), .ref_voltage_in(vin),
    .ref_current_in(iin), .mfa_voltage_in(mvin), .mfa_current_in(miin), .input_type_switch(sw),
    .pulse_train_in(pulse), .local_mode_in(local_mode), .step_select(step), .option_reference(opt),
    .keypad_write(kw), .keypad_value(kv), .freq_reference(reference_indicator), .output_active(act));
  frs_pulse_src #(.HALF(10)) frs_pulse_src_i (.aclk(aclk), .run(pulse_run), .pulse(pulse));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
  endtask : settle
  // Response ready is held from the request until the answer is seen, then one edge passes.
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] data, input logic [1:0] resp);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, data};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    check(bresp, resp);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [IDX_W-1:0] idx, input logic [15:0] exp, input logic [1:0] resp);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    check(rdata, {16'h0000, exp});
    check(rresp, resp);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  ////////////////////////////////////////////////////////////////
  task automatic t_reset_values();
    rd(IDX_REMOTE_SOURCE, 16'h0000, RESP_OKAY);
    rd(IDX_UPPER_LIMIT, 16'h0064, RESP_OKAY);
    rd(IDX_LOWER_LIMIT, 16'h0000, RESP_OKAY);
    rd(IDX_LOCAL_SOURCE, 16'h0000, RESP_OKAY);
    rd(10'h3F0, 16'h0000, RESP_SLVERR);
    wr(10'h3F0, 16'h1234, RESP_SLVERR);
    wr(IDX_REMOTE_SOURCE, 16'h000A, RESP_OKAY);
    rd(IDX_REMOTE_SOURCE, 16'h0000, RESP_OKAY);
  endtask : t_reset_values
  task automatic t_sources();
    logic [15:0] exp_tab [10];
    exp_tab = '{16'h1194, 16'h04D2, 16'h0BB8, 16'h08CA, 16'h0BB8, 16'h0BB8, 16'h0929, 16'h05DC, 16'h1770, 16'h0D80};
    knob <= 12'hBFF;
    vin <= 12'h7FF;
    iin <= 12'h7FF;
    mvin <= 12'h3FF;
    miin <= 12'hFFF;
    sw <= 1'b1;
    opt <= 16'h0D80;
    pulse_run <= 1'b1;
    wr(IDX_PRESET_BASE, 16'h04D2, RESP_OKAY);
    wr(IDX_SERIAL_REFERENCE, 16'h0929, RESP_OKAY);
    wr(IDX_PULSE_SCALE, 16'h2710, RESP_OKAY);
    for (int i = 0; i < 10; i++) begin
      wr(IDX_REMOTE_SOURCE, 16'(i), RESP_OKAY);
      settle(i == 5 ? 400 : 8);
      check(reference_indicator, exp_tab[i]);
    end
    sw <= 1'b0;
    wr(IDX_REMOTE_SOURCE, 16'h0003, RESP_OKAY);
    settle(8);
    check(act, 1'b0);
  endtask : t_sources
  task automatic t_limits();
    sw <= 1'b1;
    wr(IDX_REMOTE_SOURCE, 16'h0000, RESP_OKAY);
    wr(IDX_UPPER_LIMIT, 16'h0032, RESP_OKAY);
    settle(8);
    check(reference_indicator, 16'h0BB8);
    wr(IDX_LOWER_LIMIT, 16'h003C, RESP_OKAY);
    wr(IDX_UPPER_LIMIT, 16'h006F, RESP_OKAY);
    settle(8);
    check(reference_indicator, 16'h0E10);
    rd(IDX_UPPER_LIMIT, 16'h0032, RESP_OKAY);
    wr(IDX_UPPER_LIMIT, 16'h0064, RESP_OKAY);
    wr(IDX_LOWER_LIMIT, 16'h0000, RESP_OKAY);
    knob <= 12'h000;
    settle(8);
    check(act, 1'b0);
    wr(IDX_LOWER_LIMIT, 16'h000A, RESP_OKAY);
    settle(8);
    check(reference_indicator, 16'h0258);
    check(act, 1'b1);
    wr(IDX_LOWER_LIMIT, 16'h0000, RESP_OKAY);
  endtask : t_limits
  task automatic t_local_keypad();
    local_mode <= 1'b1;
    knob <= 12'h7FF;
    settle(8);
    check(reference_indicator, 16'h0BB8);
    wr(IDX_LOCAL_SOURCE, 16'h0001, RESP_OKAY);
    kv <= 16'h0309;
    kw <= 1'b1;
    @(posedge aclk);
    kw <= 1'b0;
    settle(8);
    check(reference_indicator, 16'h0309);
    rd(IDX_PRESET_BASE, 16'h0309, RESP_OKAY);
    wr(IDX_UPPER_LIMIT, 16'h000A, RESP_OKAY);
    settle(8);
    check(reference_indicator, 16'h0258);
    wr(IDX_UPPER_LIMIT, 16'h0064, RESP_OKAY);
    local_mode <= 1'b0;
  endtask : t_local_keypad
  task automatic t_multistep();
    wr(IDX_REMOTE_SOURCE, 16'h0001, RESP_OKAY);
    wr(IDX_PRESET_BASE + 10'h001, 16'h08AE, RESP_OKAY);
    step <= 4'h1;
    settle(8);
    check(reference_indicator, 16'h08AE);
    step <= 4'h0;
    settle(8);
    check(reference_indicator, 16'h0309);
  endtask : t_multistep
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle(4);
    t_reset_values();
    t_sources();
    t_limits();
    t_local_keypad();
    t_multistep();
    wrap_up();
  end
endmodule : frs_selector_tb
`default_nettype wire
